/* File: common/i2c_seq_defs.svh */
// Offsets, field positions, reset values and timing counts of the I2C sequencer.
// Included by the package and by every design file that decodes registers.
`ifndef I2C_SEQ_DEFS_SVH
`define I2C_SEQ_DEFS_SVH

`define OFS_CTRL 8'h00
`define OFS_RXDATA 8'h04
`define OFS_STATUS 8'h08

`define B_START 0
`define B_RSTART 1
`define B_STOP 2
`define B_RECV 3
`define B_ACKSEQ 4
`define B_ACKVAL 5
`define B_STRETCH 6
`define B_MONITOR 11
`define B_CLKREL 12

`define CTRL_RESET 16'h1000
`define TRIG_MASK 16'h001f
`define CTRL_RW_MASK 16'h1860

// Link clocks per quarter of an SCL period.
`define QUARTER_CYC 10

`endif

/* File: common/i2c_seq_pkg.sv */
// Types shared by the register side and the link side of the I2C sequencer.
// Assumes i2c_seq_defs.svh is on the include path.
`include "i2c_seq_defs.svh"

package i2c_seq_pkg;

  typedef enum logic [2:0] {
    OP_START = 3'h0,
    OP_RSTART = 3'h1,
    OP_STOP = 3'h2,
    OP_RECV = 3'h3,
    OP_ACK = 3'h4
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } link_st_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic pend;
    op_t op;
    logic req_tgl;
    logic done_seen;
    logic [7:0] rx;
    logic ack;
    logic [31:0] dat;
  } sys_state_t;

  typedef struct packed {
    link_st_t st;
    op_t op;
    logic [1:0] ph;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic scl_low;
    logic sda_low;
    logic stretch;
    logic [7:0] rx;
    logic req_seen;
    logic done_tgl;
  } link_state_t;

endpackage : i2c_seq_pkg

/* File: verification/i2c_master_sequence_control_tb.sv */
// Bench of the I2C sequencer: registers over Wishbone and bus sequences.
// Assumes a slave model on pulled-up lines resolved here.
`timescale 1ns/100ps

module i2c_master_sequence_control_tb;
  logic CLK_SYS = 1'b0;
  logic LINK_CLK = 1'b0;
  // Reset starts unknown so that its first fall also resets the link domain at once.
  logic RST_N;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, r;
  logic WB_ACK_O, SCL_OE, SDA_OE, scl_low, sda_low, last_bit, slow = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  wire logic scl = !(SCL_OE || scl_low);
  wire logic sda = !(SDA_OE || sda_low);
  int mismatches = 0;
  int num_checks = 0;
  integer seed = 32'h93b7;

  always #2.5 CLK_SYS = ~CLK_SYS;
  initial begin
    #0.7;
    forever #62.5 LINK_CLK = ~LINK_CLK;
  end
  always @(posedge scl) last_bit <= sda;

  i2c_seq_ctrl #(.QUARTER(2)) i_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(1'b1), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(4'h3), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .LINK_CLK(LINK_CLK), .SCL_I(scl), .SCL_O(),
    .SCL_OE(SCL_OE), .SDA_I(sda), .SDA_O(), .SDA_OE(SDA_OE)
  );
  i2c_slave_model i_slave (
    .scl(scl), .sda(sda), .tx_byte(tx_byte), .slow(slow), .scl_low(scl_low), .sda_low(sda_low)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= {16'h0, d};
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    r = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK_SYS);
    if (n == 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wb

  // Sets one trigger, sees it pending, then polls until hardware clears it.
  task automatic trig(input logic [15:0] d);
    int n = 0;
    wb(1'b1, 8'h00, d);
    wb(1'b0, 8'h00, 16'h0);
    check(r[4:0], d[4:0]);
    while (r[4:0] !== 5'h0 && n < 4000) begin
      wb(1'b0, 8'h00, 16'h0);
      n++;
    end
    if (n == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : trig

  initial begin
    logic [7:0] b;
    logic a;
    RST_N <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (100) @(posedge CLK_SYS);
    wb(1'b0, 8'h00, 16'h0);
    check(r, 32'h1000);
    wb(1'b0, 8'h0c, 16'h0);
    check(r, 32'h0);
    wb(1'b1, 8'h00, 16'h0040);
    repeat (200) @(posedge CLK_SYS);
    check(SCL_OE, 1'b1);
    wb(1'b1, 8'h00, 16'h1040);
    repeat (200) @(posedge CLK_SYS);
    check(SCL_OE, 1'b0);
    wb(1'b1, 8'h00, 16'h0000);
    repeat (200) @(posedge CLK_SYS);
    check(SCL_OE, 1'b0);
    wb(1'b1, 8'h00, 16'h1800);
    wb(1'b1, 8'h00, 16'h1801);
    wb(1'b0, 8'h00, 16'h0);
    check(r, 32'h1800);
    wb(1'b1, 8'h00, 16'h1000);
    for (int k = 0; k < 3; k++) begin
      slow <= k[0];
      trig(16'h1001);
      for (int j = 0; j < 2; j++) begin
        b = (k == 0) ? {8{j[0]}} : 8'($random(seed));
        a = (k == 0) ? j[0] : 1'($random(seed));
        tx_byte <= b;
        trig(16'h1008);
        wb(1'b0, 8'h04, 16'h0);
        check(r, {24'h0, b});
        trig({10'h040, a, 5'h10});
        check(last_bit, a);
        if (j == 0) begin
          trig(16'h1002);
        end
      end
      trig(16'h1004);
      check({scl, sda}, 2'b11);
      wb(1'b0, 8'h08, 16'h0);
      check(r, 32'h6);
    end
    tally_and_finish();
  end
endmodule : i2c_master_sequence_control_tb

/* File: verification/i2c_seq_checker.sv */
// Port assertions of the I2C sequencer, bound into i2c_seq_ctrl.
// Only the start-to-clock bound scales with the quarter period that the bind passes in; the fixed counts assume at least 2.
`timescale 1ns/100ps

module i2c_seq_checker #(
  parameter int QUARTER = 2
) (
  // Clocks and reset
  input wire logic CLK_SYS,
  input wire logic LINK_CLK,
  input wire logic RST_N,
  // Bus and lines
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_O,
  input wire logic SDA_OE
);
  // Two quarters from start hold to clock low, plus slack for synchroniser stalls.
  localparam int LEAD_MAX = 2 * QUARTER + 4;

  AST_ACK_NEXT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  AST_ACK_ONE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
  AST_OPEN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !SCL_O && !SDA_O) else $error("line driven high");
  AST_RST_IDLE: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> !SCL_OE && !SDA_OE) else $error("pulled after reset");
  AST_SETUP: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $rose(SDA_OE) && !SCL_OE |-> !SCL_OE [*2]) else $error("short setup");
  AST_HOLD: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $rose(SDA_OE) && !SCL_OE |-> ##[1:LEAD_MAX] SCL_OE) else $error("no clock after start");
  AST_STOP: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $fell(SDA_OE) && !SCL_OE |-> !SCL_OE [*4]) else $error("clock after stop");
  AST_HIGH: assert property (@(posedge LINK_CLK) disable iff (!RST_N)
    $fell(SCL_OE) |-> !SCL_OE [*4]) else $error("short high time");
endmodule : i2c_seq_checker

bind i2c_seq_ctrl i2c_seq_checker #(.QUARTER(QUARTER)) i_chk (
  .CLK_SYS(CLK_SYS), .LINK_CLK(LINK_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE)
);

/* File: verification/i2c_slave_model.sv */
// Behavioural I2C slave sending one byte MSB first after each start.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/100ps

module i2c_slave_model (
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Controls
  input wire logic [7:0] tx_byte,
  input wire logic slow,
  // Pull-downs
  output logic scl_low,
  output logic sda_low
);
  logic [3:0] cnt = 4'hf;
  initial scl_low = 1'b0;
  always @(negedge sda) if (scl) cnt = 4'h0;
  always @(posedge sda) if (scl) cnt = 4'hf;
  always @(negedge scl) begin
    if (cnt != 4'hf) cnt = cnt + 4'h1;
    if (slow) begin
      scl_low = 1'b1;
      #600 scl_low = 1'b0;
    end
  end
  // Data changes only while the clock is low; released bits fall to the pull-up.
  assign sda_low = cnt >= 4'h1 && cnt <= 4'h8 && !tx_byte[4'h8 - cnt];
endmodule : i2c_slave_model

/* File: verilog/i2c_link_engine.sv */
// Bus-side sequencer of the I2C master, clocked by the link clock.
// Commands arrive by a request toggle with op and ack value held stable;
// completion is returned by a done toggle with the received byte held stable.
`timescale 1ns/100ps
`include "i2c_seq_defs.svh"

module i2c_link_engine import i2c_seq_pkg::*; #(
  parameter int QUARTER = `QUARTER_CYC
) (
  // Link clock and asynchronous reset
  input wire logic link_clk,
  input wire logic rst_n,
  // Requests from the register domain
  input wire logic ce,
  input wire logic req_tgl,
  input wire op_t op,
  input wire logic ack_value,
  input wire logic hold,
  // Answers to the register domain
  output logic done_tgl,
  output logic [7:0] rx_byte,
  // Open-drain bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);

  localparam logic [7:0] QM1 = 8'(QUARTER - 1);

  link_state_t q, d;
  logic [1:0] rst_q;
  logic lrst_n;
  logic req_s, hold_s, ce_s, scl_s, sda_s;
  logic stall, last;

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign lrst_n = rst_q[1];

  level_sync #(.W(5)) u_sync (
    .clk(link_clk),
    .rst_n(lrst_n),
    .din({req_tgl, hold, ce, scl_i, sda_i}),
    .dout({req_s, hold_s, ce_s, scl_s, sda_s})
  );

  // A slave holding SCL low at the end of the first high quarter (phase 1) freezes the sequence.
  assign stall = (q.ph == 2'd1) && (q.cnt == QM1) && !scl_s;
  assign last = (q.cnt == QM1) && !stall;

  always_comb begin
    d = q;
    d.stretch = 1'b0;
    if (q.st == ST_IDLE) begin
      if (req_s != q.req_seen) begin
        d.req_seen = req_s;
        d.op = op;
        d.ph = 2'd0;
        d.cnt = 8'h00;
        d.bitn = 3'h0;
        d.st = ST_RUN;
        case (op)
          OP_START: begin
            d.scl_low = 1'b0;
            d.sda_low = 1'b0;
          end
          OP_STOP: d.sda_low = 1'b1;
          OP_ACK: d.sda_low = ~ack_value;
          default: d.sda_low = 1'b0;
        endcase
      end else begin
        d.stretch = hold_s;
      end
    end else begin
      if (!last) begin
        d.cnt = stall ? q.cnt : q.cnt + 8'h01;
      end else begin
        d.cnt = 8'h00;
        d.ph = q.ph + 2'd1;
        case (q.ph)
          2'd0: begin
            if (q.op == OP_START) begin
              d.sda_low = 1'b1;
            end else begin
              d.scl_low = 1'b0;
            end
          end
          2'd1: begin
            if (q.op == OP_RSTART) begin
              d.sda_low = 1'b1;
            end else if (q.op == OP_STOP) begin
              d.sda_low = 1'b0;
            end else if (q.op == OP_RECV) begin
              d.rx = {q.rx[6:0], sda_s};
            end
          end
          2'd2: begin
            if (q.op != OP_STOP) begin
              d.scl_low = 1'b1;
            end
          end
          default: begin
            if (q.op == OP_RECV && q.bitn != 3'h7) begin
              d.bitn = q.bitn + 3'h1;
            end else begin
              if (q.op == OP_ACK) begin
                d.sda_low = 1'b0;
              end
              d.done_tgl = ~q.done_tgl;
              d.st = ST_IDLE;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      q <= '{st: ST_IDLE, op: OP_START, default: '0};
    end else if (ce_s) begin
      q <= d;
    end
  end

  assign done_tgl = q.done_tgl;
  assign rx_byte = q.rx;
  assign scl_oe = q.scl_low | q.stretch;
  assign sda_oe = q.sda_low;

endmodule : i2c_link_engine

/* File: verilog/i2c_seq_ctrl.sv */
// Register side of the I2C master sequencer with a classic Wishbone slave.
// Assumes a free-running link clock for the bus engine and open-drain pads
// that pull a line low while its output enable is high.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "i2c_seq_defs.svh"

module i2c_seq_ctrl import i2c_seq_pkg::*; #(
  parameter int QUARTER = `QUARTER_CYC
) (
  // System clock, reset and clock enable
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Link clock and I2C lines
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  sys_state_t q, d;
  logic [1:0] rst_q;
  logic rst_n;
  logic done_tgl, done_s, scl_s, sda_s;
  logic [7:0] rx_byte;
  logic hit, trig_ok;
  logic [15:0] wmask, wval;
  op_t pick;
  logic [4:0] pick_bit;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // The bus lines are resampled here only for status readback.
  level_sync #(.W(3)) u_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .din({done_tgl, SCL_I, SDA_I}),
    .dout({done_s, scl_s, sda_s})
  );

  i2c_link_engine #(.QUARTER(QUARTER)) u_engine (
    .link_clk(LINK_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .req_tgl(q.req_tgl),
    .op(q.op),
    .ack_value(q.ctrl[`B_ACKVAL]),
    .hold(q.ctrl[`B_STRETCH] & ~q.ctrl[`B_CLKREL]),
    .done_tgl(done_tgl),
    .rx_byte(rx_byte),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .scl_oe(SCL_OE),
    .sda_oe(SDA_OE)
  );

  // Only the highest-priority trigger of a write is taken.
  always_comb begin
    pick = OP_START;
    pick_bit = 5'h01;
    if (WB_DAT_I[`B_START]) begin
      pick = OP_START;
      pick_bit = 5'h01;
    end else if (WB_DAT_I[`B_RSTART]) begin
      pick = OP_RSTART;
      pick_bit = 5'h02;
    end else if (WB_DAT_I[`B_STOP]) begin
      pick = OP_STOP;
      pick_bit = 5'h04;
    end else if (WB_DAT_I[`B_RECV]) begin
      pick = OP_RECV;
      pick_bit = 5'h08;
    end else if (WB_DAT_I[`B_ACKSEQ]) begin
      pick = OP_ACK;
      pick_bit = 5'h10;
    end
  end

  assign wmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}} & `CTRL_RW_MASK;
  assign wval = (q.ctrl & ~wmask) | (WB_DAT_I[15:0] & wmask);

  // Triggers are refused while one is pending or the monitor mode is on.
  assign trig_ok = WB_SEL_I[0] && !q.pend && !q.ctrl[`B_MONITOR]
                   && (WB_DAT_I[4:0] != 5'h00);

  always_comb begin
    d = q;
    hit = WB_CYC_I && WB_STB_I && !q.ack;
    d.ack = hit;
    if (done_s != q.done_seen) begin
      d.done_seen = done_s;
      d.pend = 1'b0;
      d.ctrl = q.ctrl & ~`TRIG_MASK;
      if (q.op == OP_RECV) begin
        d.rx = rx_byte;
      end
    end
    if (hit) begin
      d.dat = 32'h0000_0000;
      if (WB_ADR_I == `OFS_CTRL) begin
        d.dat = {16'h0000, q.ctrl};
        if (WB_WE_I) begin
          d.ctrl = (d.ctrl & `TRIG_MASK) | (wval & ~`TRIG_MASK);
          if (trig_ok) begin
            d.ctrl[4:0] = pick_bit;
            d.op = pick;
            d.pend = 1'b1;
            d.req_tgl = ~q.req_tgl;
          end
        end
      end else if (WB_ADR_I == `OFS_RXDATA) begin
        d.dat = {24'h00_0000, q.rx};
      end else if (WB_ADR_I == `OFS_STATUS) begin
        d.dat = {29'h0, sda_s, scl_s, q.pend};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{ctrl: `CTRL_RESET, op: OP_START, default: '0};
    end else if (CE) begin
      q <= d;
    end
  end

  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = q.dat;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;

endmodule : i2c_seq_ctrl

/* File: verilog/level_sync.sv */
// Two-flop synchroniser for a group of independent levels or toggles.
// Each bit must be a level or a toggle; multi-bit words must not pass here.
`timescale 1ns/100ps

module level_sync #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [1:0][W-1:0] stage_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[0], din};
    end
  end

  assign dout = stage_q[1];

endmodule : level_sync
